// ==== logic/lighting_ballast_command_link.sv ====
// Ballast side of the two-wire lighting command link: receiver, command executer, backward reply
// Overview of operation
// - Forward frame is one start bit, sixteen data bits, two stop bits.
// - Bit timing runs at 1200 baud, derived from the system clock.
// - One six-bit short address gives up to 64 independent ballasts.
// - Sixteen group membership flags; act on commands to any member group.
// - Sixteen stored scene levels, applied when the scene is recalled.
// - Level code spans 254 logarithmic steps from full down to 0.1 percent.
// - Requested levels below the minimum level are raised to it.
// - Accept frames for own short address, a member group, or broadcast.
// - Execute direct level, on, off, store scene and recall scene.
// - Answer status, lamp failure and level queries to the master.
// - Configuration commands set the short address and group memberships.
// - Reserved command codes cause no action at all.
// - Replies short the control line during each low half-bit.
// - Lamp switched on and off internally; mains stays present.
// - Address, groups and scenes kept in non-volatile store, restored at power-up.
module lighting_ballast_command_link #(
	parameter int unsigned HALF_BIT_CYCLES = ballast_link_pkg::HALF_BIT_CYCLES,
	parameter logic [7:0] MIN_LEVEL = ballast_link_pkg::LEVEL_MIN_RST
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic nrst,
	// Control line
	input wire logic control_line_terminal,
	output logic backward_short_q,
	// Lamp
	input wire logic lamp_fail,
	output logic lamp_on_q,
	output logic [7:0] arc_level_q,
	// Non-volatile settings
	input wire logic nv_restore,
	input wire logic nv_addr_valid,
	input wire logic [5:0] nv_short_addr,
	input wire logic [15:0] nv_groups,
	input wire logic [15:0][7:0] nv_scenes,
	output logic addr_valid_q,
	output logic [5:0] short_addr_q,
	output logic [15:0] groups_q,
	output logic [15:0][7:0] scenes_q,
	output logic nv_save_q,
	// Diagnostics
	output logic frame_err_q
);

	localparam logic [ballast_link_pkg::TMR_W-1:0] HALF_RELOAD = ballast_link_pkg::TMR_W'(HALF_BIT_CYCLES - 1);
	localparam logic [ballast_link_pkg::TMR_W-1:0] QUARTER_RELOAD = ballast_link_pkg::TMR_W'(HALF_BIT_CYCLES / 2 - 1);

	logic line;
	ballast_link_pkg::link_state_type state_q, state_d;
	logic [ballast_link_pkg::TMR_W-1:0] tmr_q, tmr_d;
	logic [5:0] idx_q, idx_d;
	logic first_half_q, first_half_d;
	logic [16:0] shift_q, shift_d;
	logic [7:0] dtr_q, dtr_d;
	logic [7:0] reply_q, reply_d;
	logic backward_short_d, lamp_on_d, nv_save_d, frame_err_d, addr_valid_d;
	logic [7:0] arc_level_d;
	logic [5:0] short_addr_d;
	logic [15:0] groups_d;
	logic [15:0][7:0] scenes_d;
	logic [7:0] addr_byte, data_byte, req_level, tx_byte;
	logic selected, req_valid, tx_bit;
	logic [3:0] tx_bit_idx;

	// ****************************************
	// Line input
	// ****************************************
	line_sync u_line_sync (
		.mclk(mclk),
		.nrst(nrst),
		.raw_in(control_line_terminal),
		.level_q(line)
	);

	// ****************************************
	// Next-state logic
	// ****************************************
	always_comb begin
		state_d = state_q;
		tmr_d = tmr_q;
		idx_d = idx_q;
		first_half_d = first_half_q;
		shift_d = shift_q;
		dtr_d = dtr_q;
		reply_d = reply_q;
		backward_short_d = 1'b0;
		lamp_on_d = lamp_on_q;
		arc_level_d = arc_level_q;
		addr_valid_d = addr_valid_q;
		short_addr_d = short_addr_q;
		groups_d = groups_q;
		scenes_d = scenes_q;
		nv_save_d = 1'b0;
		frame_err_d = 1'b0;
		req_valid = 1'b0;
		req_level = ballast_link_pkg::LEVEL_OFF;
		addr_byte = shift_q[15:8];
		data_byte = shift_q[7:0];
		// Own short address, a member group, or everyone
		selected = (!addr_byte[7] && addr_valid_q && addr_byte[6:1] == short_addr_q)
			|| (addr_byte[7:5] == ballast_link_pkg::ADDR_GROUP_TAG && groups_q[addr_byte[4:1]])
			|| (addr_byte[7:1] == ballast_link_pkg::ADDR_BROADCAST);
		tx_bit_idx = 4'(idx_q[4:1]);
		tx_byte = reply_q << (tx_bit_idx - 4'h1);
		tx_bit = (tx_bit_idx == 4'h0) ? 1'b1 : tx_byte[7];
		unique case (state_q)
			ballast_link_pkg::ST_IDLE: begin
				// Falling edge of the start bit; first sample lands mid first half
				if (!line) begin
					state_d = ballast_link_pkg::ST_RX;
					tmr_d = QUARTER_RELOAD;
					idx_d = 6'h00;
				end
			end
			ballast_link_pkg::ST_RX: begin
				if (tmr_q != '0) begin
					tmr_d = tmr_q - 1'b1;
				end else begin
					tmr_d = HALF_RELOAD;
					idx_d = idx_q + 6'h01;
					if (idx_q <= ballast_link_pkg::RX_LAST_DATA_HALF) begin
						if (!idx_q[0]) begin
							first_half_d = line;
						end else if (line == first_half_q) begin
							// No mid-bit transition
							frame_err_d = 1'b1;
							state_d = ballast_link_pkg::ST_IDLE;
						end else begin
							shift_d = {shift_q[15:0], line};
						end
					end else if (!line) begin
						// Stop bits must stay released
						frame_err_d = 1'b1;
						state_d = ballast_link_pkg::ST_IDLE;
					end
					if (idx_q == ballast_link_pkg::RX_LAST_HALF && line) begin
						state_d = ballast_link_pkg::ST_EXEC;
					end
				end
			end
			ballast_link_pkg::ST_EXEC: begin
				state_d = ballast_link_pkg::ST_IDLE;
				if (!shift_q[16]) begin
					frame_err_d = 1'b1;
				end else if (addr_byte == ballast_link_pkg::ADDR_DATA_LOAD) begin
					dtr_d = data_byte;
				end else if (selected && !addr_byte[0]) begin
					req_valid = data_byte != ballast_link_pkg::LEVEL_MASK;
					req_level = data_byte;
				end else if (selected) begin
					if (data_byte == ballast_link_pkg::CMD_OFF) begin
						req_valid = 1'b1;
					end else if (data_byte == ballast_link_pkg::CMD_RECALL_MAX) begin
						req_valid = 1'b1;
						req_level = ballast_link_pkg::LEVEL_MAX;
					end else if (data_byte[7:4] == ballast_link_pkg::CMD_GO_SCENE) begin
						req_valid = scenes_q[data_byte[3:0]] != ballast_link_pkg::LEVEL_MASK;
						req_level = scenes_q[data_byte[3:0]];
					end else if (data_byte[7:4] == ballast_link_pkg::CMD_STORE_SCENE) begin
						scenes_d[data_byte[3:0]] = lamp_on_q ? arc_level_q : ballast_link_pkg::LEVEL_OFF;
						nv_save_d = 1'b1;
					end else if (data_byte[7:4] == ballast_link_pkg::CMD_ADD_GROUP) begin
						groups_d[data_byte[3:0]] = 1'b1;
						nv_save_d = 1'b1;
					end else if (data_byte[7:4] == ballast_link_pkg::CMD_REMOVE_GROUP) begin
						groups_d[data_byte[3:0]] = 1'b0;
						nv_save_d = 1'b1;
					end else if (data_byte == ballast_link_pkg::CMD_SET_SHORT_ADDR) begin
						// Data 0AAAAAA1 assigns, all ones clears the address
						addr_valid_d = dtr_q != ballast_link_pkg::LEVEL_MASK;
						short_addr_d = dtr_q[6:1];
						nv_save_d = 1'b1;
					end else if (data_byte == ballast_link_pkg::CMD_QUERY_STATUS) begin
						reply_d = {5'h00, !addr_valid_q, lamp_on_q, lamp_fail};
						state_d = ballast_link_pkg::ST_SETTLE;
					end else if (data_byte == ballast_link_pkg::CMD_QUERY_LAMP_FAIL) begin
						// A negative answer is silence
						reply_d = ballast_link_pkg::REPLY_YES;
						state_d = lamp_fail ? ballast_link_pkg::ST_SETTLE : ballast_link_pkg::ST_IDLE;
					end else if (data_byte == ballast_link_pkg::CMD_QUERY_LEVEL) begin
						reply_d = lamp_on_q ? arc_level_q : ballast_link_pkg::LEVEL_OFF;
						state_d = ballast_link_pkg::ST_SETTLE;
					end
					// Any other code falls through untouched
				end
				tmr_d = HALF_RELOAD;
				idx_d = 6'h00;
			end
			ballast_link_pkg::ST_SETTLE: begin
				if (tmr_q != '0) begin
					tmr_d = tmr_q - 1'b1;
				end else begin
					tmr_d = HALF_RELOAD;
					idx_d = idx_q + 6'h01;
					if (idx_q[4:0] == ballast_link_pkg::SETTLE_HALVES) begin
						state_d = ballast_link_pkg::ST_TX;
						idx_d = 6'h00;
					end
				end
			end
			ballast_link_pkg::ST_TX: begin
				// Start bit then eight data bits, MSB first; low half means short
				if (idx_q[4:0] <= ballast_link_pkg::TX_LAST_DATA_HALF) begin
					backward_short_d = idx_q[0] ? !tx_bit : tx_bit;
				end
				if (tmr_q != '0) begin
					tmr_d = tmr_q - 1'b1;
				end else begin
					tmr_d = HALF_RELOAD;
					idx_d = idx_q + 6'h01;
					if (idx_q[4:0] == ballast_link_pkg::TX_LAST_HALF) begin
						state_d = ballast_link_pkg::ST_IDLE;
						backward_short_d = 1'b0;
					end
				end
			end
		endcase
		if (req_valid) begin
			if (req_level == ballast_link_pkg::LEVEL_OFF) begin
				lamp_on_d = 1'b0;
			end else begin
				lamp_on_d = 1'b1;
				if (req_level < MIN_LEVEL) begin
					arc_level_d = MIN_LEVEL;
				end else if (req_level > ballast_link_pkg::LEVEL_MAX) begin
					arc_level_d = ballast_link_pkg::LEVEL_MAX;
				end else begin
					arc_level_d = req_level;
				end
			end
		end
		if (nv_restore) begin
			addr_valid_d = nv_addr_valid;
			short_addr_d = nv_short_addr;
			groups_d = nv_groups;
			scenes_d = nv_scenes;
		end
	end

	// ****************************************
	// State registers
	// ****************************************
	always_ff @(posedge mclk) begin
		if (!nrst) begin
			state_q <= ballast_link_pkg::ST_IDLE;
			tmr_q <= '0;
			idx_q <= 6'h00;
			first_half_q <= 1'b1;
			shift_q <= 17'h00000;
			dtr_q <= ballast_link_pkg::DATA_RST;
			reply_q <= ballast_link_pkg::DATA_RST;
			backward_short_q <= 1'b0;
			lamp_on_q <= 1'b0;
			arc_level_q <= ballast_link_pkg::LEVEL_MAX;
			addr_valid_q <= 1'b0;
			short_addr_q <= ballast_link_pkg::SHORT_ADDR_RST;
			groups_q <= ballast_link_pkg::GROUPS_RST;
			scenes_q <= {16{ballast_link_pkg::LEVEL_MASK}};
			nv_save_q <= 1'b0;
			frame_err_q <= 1'b0;
		end else begin
			state_q <= state_d;
			tmr_q <= tmr_d;
			idx_q <= idx_d;
			first_half_q <= first_half_d;
			shift_q <= shift_d;
			dtr_q <= dtr_d;
			reply_q <= reply_d;
			backward_short_q <= backward_short_d;
			lamp_on_q <= lamp_on_d;
			arc_level_q <= arc_level_d;
			addr_valid_q <= addr_valid_d;
			short_addr_q <= short_addr_d;
			groups_q <= groups_d;
			scenes_q <= scenes_d;
			nv_save_q <= nv_save_d;
			frame_err_q <= frame_err_d;
		end
	end

endmodule

// ==== logic/ballast_link_pkg.sv ====
// Constants shared by the ballast command link
package ballast_link_pkg;

	// ****************************************
	// Timing
	// ****************************************
	localparam int unsigned MCLK_HZ = 40_000_000;
	localparam int unsigned LINE_BAUD = 1200;
	// Half bit period rounded down to whole cycles (16666 at 40 MHz)
	localparam int unsigned HALF_BIT_CYCLES = MCLK_HZ / (2 * LINE_BAUD);
	localparam int unsigned TMR_W = 16;
	localparam int unsigned SYNC_STAGES = 3;

	// ****************************************
	// Frame layout, counted in half bits
	// ****************************************
	localparam logic [5:0] RX_LAST_DATA_HALF = 6'h21;
	localparam logic [5:0] RX_LAST_HALF = 6'h25;
	localparam logic [4:0] TX_LAST_DATA_HALF = 5'h11;
	localparam logic [4:0] TX_LAST_HALF = 5'h15;
	localparam logic [4:0] SETTLE_HALVES = 5'h07;

	// ****************************************
	// Addressing and levels
	// ****************************************
	localparam logic [7:0] ADDR_DATA_LOAD = 8'ha3;
	localparam logic [6:0] ADDR_BROADCAST = 7'h7f;
	localparam logic [2:0] ADDR_GROUP_TAG = 3'h4;
	localparam logic [7:0] LEVEL_OFF = 8'h00;
	localparam logic [7:0] LEVEL_MIN_RST = 8'h7e;
	localparam logic [7:0] LEVEL_MAX = 8'hfe;
	localparam logic [7:0] LEVEL_MASK = 8'hff;
	localparam logic [7:0] REPLY_YES = 8'hff;
	localparam logic [5:0] SHORT_ADDR_RST = 6'h00;
	localparam logic [15:0] GROUPS_RST = 16'h0000;
	localparam logic [7:0] DATA_RST = 8'h00;

	// ****************************************
	// Command codes (upper nibble selects a family)
	// ****************************************
	localparam logic [7:0] CMD_OFF = 8'h00;
	localparam logic [7:0] CMD_RECALL_MAX = 8'h05;
	localparam logic [3:0] CMD_GO_SCENE = 4'h1;
	localparam logic [3:0] CMD_STORE_SCENE = 4'h4;
	localparam logic [3:0] CMD_ADD_GROUP = 4'h6;
	localparam logic [3:0] CMD_REMOVE_GROUP = 4'h7;
	localparam logic [7:0] CMD_SET_SHORT_ADDR = 8'h80;
	localparam logic [7:0] CMD_QUERY_STATUS = 8'h90;
	localparam logic [7:0] CMD_QUERY_LAMP_FAIL = 8'h92;
	localparam logic [7:0] CMD_QUERY_LEVEL = 8'ha0;

	typedef enum logic [4:0] {
		ST_IDLE = 5'h01,
		ST_RX = 5'h02,
		ST_EXEC = 5'h04,
		ST_SETTLE = 5'h08,
		ST_TX = 5'h10
	} link_state_type;

endpackage

// ==== logic/line_sync.sv ====
// Three-stage synchroniser that accepts a change once stages two and three agree
module line_sync (
	// Clock and reset
	input wire logic mclk,
	input wire logic nrst,
	// Raw and filtered level
	input wire logic raw_in,
	output logic level_q
);

	logic [2:0] stage_q;
	logic [2:0] stage_d;
	logic level_d;

	always_comb begin
		stage_d = {stage_q[1:0], raw_in};
		level_d = level_q;
		if (stage_q[2] == stage_q[1]) begin
			level_d = stage_q[2];
		end
	end

	always_ff @(posedge mclk) begin
		if (!nrst) begin
			stage_q <= 3'h7;
			level_q <= 1'b1;
		end else begin
			stage_q <= stage_d;
			level_q <= level_d;
		end
	end

endmodule

// ==== verif/ballast_link_monitor.sv ====
// Port checker for the ballast command link
module ballast_link_monitor #(
	parameter int unsigned HALF_BIT_CYCLES = 20,
	parameter logic [7:0] MIN_LEVEL = 8'h7e
) (
	// Clock and reset
	input wire logic mclk,
	input wire logic nrst,
	// Control line
	input wire logic control_line_terminal,
	input wire logic backward_short_q,
	// Lamp
	input wire logic lamp_fail,
	input wire logic lamp_on_q,
	input wire logic [7:0] arc_level_q,
	// Non-volatile settings
	input wire logic nv_restore,
	input wire logic nv_addr_valid,
	input wire logic [5:0] nv_short_addr,
	input wire logic [15:0] nv_groups,
	input wire logic [15:0][7:0] nv_scenes,
	input wire logic addr_valid_q,
	input wire logic [5:0] short_addr_q,
	input wire logic [15:0] groups_q,
	input wire logic [15:0][7:0] scenes_q,
	input wire logic nv_save_q,
	// Diagnostics
	input wire logic frame_err_q
);
	timeunit 1ns;
	timeprecision 100ps;
	// ****
	// Short-run length counter
	// ****
	int unsigned run_q, run_d;
	always_comb begin
		run_d = backward_short_q ? run_q + 1 : 0;
	end
	always_ff @(posedge mclk) begin
		run_q <= nrst ? run_d : 0;
	end
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!nrst);
	sequence s_first_half;
		backward_short_q [*8];
	endsequence
	chk_reset_quiet: assert property (disable iff (1'b0) !nrst |=> !lamp_on_q && !backward_short_q && arc_level_q == 8'hfe)
		else $error("outputs not at reset values");
	chk_level_floor: assert property (lamp_on_q |-> arc_level_q >= MIN_LEVEL && arc_level_q <= 8'hfe)
		else $error("arc level out of range");
	chk_restore_load: assert property (nv_restore |=> short_addr_q == $past(nv_short_addr)
		&& groups_q == $past(nv_groups) && addr_valid_q == $past(nv_addr_valid) && scenes_q == $past(nv_scenes))
		else $error("restore not loaded");
	chk_save_on_change: assert property ($changed(groups_q) && !$past(nv_restore) |-> ##[0:1] nv_save_q)
		else $error("group change without save pulse");
	chk_save_single: assert property (nv_save_q |=> !nv_save_q)
		else $error("save pulse too long");
	chk_err_single: assert property (frame_err_q |=> !frame_err_q)
		else $error("error pulse too long");
	chk_reply_start: assert property ($rose(backward_short_q) |-> s_first_half)
		else $error("reply start half too short");
	chk_half_width: assert property ($fell(backward_short_q) |-> run_q + 2 >= HALF_BIT_CYCLES
		&& run_q <= 2 * HALF_BIT_CYCLES + 2)
		else $error("reply low phase width wrong");
endmodule
bind lighting_ballast_command_link ballast_link_monitor #(.HALF_BIT_CYCLES(HALF_BIT_CYCLES), .MIN_LEVEL(MIN_LEVEL)) mon (
	.mclk(mclk), .nrst(nrst), .control_line_terminal(control_line_terminal), .backward_short_q(backward_short_q),
	.lamp_fail(lamp_fail), .lamp_on_q(lamp_on_q), .arc_level_q(arc_level_q), .nv_restore(nv_restore),
	.nv_addr_valid(nv_addr_valid), .nv_short_addr(nv_short_addr), .nv_groups(nv_groups), .nv_scenes(nv_scenes),
	.addr_valid_q(addr_valid_q), .short_addr_q(short_addr_q), .groups_q(groups_q), .scenes_q(scenes_q),
	.nv_save_q(nv_save_q), .frame_err_q(frame_err_q));

// ==== verif/master_ctrl_model.sv ====
// Master controller model: sends forward frames and decodes backward replies
module master_ctrl_model #(
	parameter int unsigned H = 20
) (
	// Clock
	input wire logic mclk,
	// Line
	input wire logic backward_short_q,
	output logic line_drive
);
	timeunit 1ns;
	timeprecision 100ps;
	initial line_drive = 1'b1;
	task automatic half(input logic v);
		line_drive <= v;
		repeat (H) @(posedge mclk);
	endtask
	// Start bit, sixteen bits MSB first, two stop bits, bi-phase halves
	task automatic send(input logic [15:0] f, input logic bad_stop);
		half(1'b0);
		half(1'b1);
		for (int i = 15; i >= 0; i--) begin
			half(!f[i]);
			half(f[i]);
		end
		half(1'b1);
		half(!bad_stop);
		half(1'b1);
		half(1'b1);
	endtask
	// Bit value is the released or shorted level of each second half
	task automatic reply(output logic got, output logic [7:0] b);
		int n;
		got = 1'b0;
		b = 8'h00;
		n = 0;
		while (!backward_short_q && n < 400) begin
			@(posedge mclk);
			n++;
		end
		if (backward_short_q) begin
			got = 1'b1;
			repeat (3 * H + H / 2 + 1) @(posedge mclk);
			for (int i = 7; i >= 0; i--) begin
				b[i] = !backward_short_q;
				if (i > 0) repeat (2 * H) @(posedge mclk);
			end
			repeat (5 * H + H / 2) @(posedge mclk);
		end
	endtask
endmodule

// ==== verif/test_lighting_ballast_command_link.sv ====
// Self-checking bench for the ballast command link
module test_lighting_ballast_command_link;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int unsigned H = 20;
	logic mclk = 1'b0;
	logic nrst = 1'b0;
	logic lamp_fail = 1'b0;
	logic nv_restore = 1'b0;
	logic nv_addr_valid = 1'b0;
	logic [5:0] nv_short_addr = 6'h00;
	logic [15:0] nv_groups = 16'h0000;
	logic [15:0][7:0] nv_scenes = '1;
	logic line_drive, backward_short_q, lamp_on_q, addr_valid_q, nv_save_q, frame_err_q, control_line_terminal;
	logic [7:0] arc_level_q, rb;
	logic [5:0] short_addr_q;
	logic [15:0] groups_q;
	logic [15:0][7:0] scenes_q;
	logic got;
	logic ferr = 1'b0;
	int error_cnt = 0;
	int num_checks = 0;
	int saves = 0;
	// Shorting switch pulls the shared line low
	assign control_line_terminal = line_drive & ~backward_short_q;
	always #12.5 mclk = ~mclk;
	always @(posedge mclk) if (frame_err_q === 1'b1) ferr <= 1'b1;
	// Counts save pulses to the non-volatile store
	always @(posedge mclk) if (nv_save_q === 1'b1) saves <= saves + 1;
	lighting_ballast_command_link #(.HALF_BIT_CYCLES(H)) uut (.mclk(mclk), .nrst(nrst),
		.control_line_terminal(control_line_terminal), .backward_short_q(backward_short_q), .lamp_fail(lamp_fail),
		.lamp_on_q(lamp_on_q), .arc_level_q(arc_level_q), .nv_restore(nv_restore), .nv_addr_valid(nv_addr_valid),
		.nv_short_addr(nv_short_addr), .nv_groups(nv_groups), .nv_scenes(nv_scenes), .addr_valid_q(addr_valid_q),
		.short_addr_q(short_addr_q), .groups_q(groups_q), .scenes_q(scenes_q), .nv_save_q(nv_save_q),
		.frame_err_q(frame_err_q));
	master_ctrl_model #(.H(H)) m (.mclk(mclk), .backward_short_q(backward_short_q), .line_drive(line_drive));
	// ****
	// Helpers
	// ****
	task automatic chk(input logic [127:0] g, input logic [127:0] e);
		num_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("CHECK FAILED at %0t: got %0h expected %0h", $time, g, e);
		end
	endtask
	task automatic frm(input logic [7:0] a, input logic [7:0] d);
		m.send({a, d}, 1'b0);
		repeat (4) @(posedge mclk);
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", num_checks, error_cnt);
		if (error_cnt == 0 && num_checks > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask
	// ****
	// Scenarios
	// ****
	task automatic t_restore();
		chk({lamp_on_q, arc_level_q, groups_q, scenes_q[0]}, {1'b0, 8'hfe, 16'h0000, 8'hff});
		nv_addr_valid <= 1'b1;
		nv_short_addr <= 6'h05;
		nv_groups <= 16'h0008;
		nv_scenes[3] <= 8'h90;
		nv_restore <= 1'b1;
		@(posedge mclk);
		nv_restore <= 1'b0;
		repeat (2) @(posedge mclk);
		chk({addr_valid_q, short_addr_q, groups_q, scenes_q[3]}, {1'b1, 6'h05, 16'h0008, 8'h90});
	endtask
	task automatic t_level();
		frm(8'h0a, 8'h90);
		chk({lamp_on_q, arc_level_q}, {1'b1, 8'h90});
		frm(8'h0a, 8'h30);
		chk(arc_level_q, 8'h7e);
		frm(8'h0a, 8'hff);
		frm(8'h0c, 8'hc0);
		chk(arc_level_q, 8'h7e);
	endtask
	task automatic t_group();
		frm(8'h87, 8'h00);
		chk(lamp_on_q, 1'b0);
		frm(8'h85, 8'h05);
		chk(lamp_on_q, 1'b0);
		frm(8'hff, 8'h05);
		chk({lamp_on_q, arc_level_q}, {1'b1, 8'hfe});
	endtask
	task automatic t_scene();
		frm(8'hfe, 8'ha0);
		frm(8'hff, 8'h42);
		chk(scenes_q[2], 8'ha0);
		frm(8'h0b, 8'h00);
		frm(8'h0b, 8'h12);
		chk({lamp_on_q, arc_level_q}, {1'b1, 8'ha0});
		frm(8'h0b, 8'h13);
		chk(arc_level_q, 8'h90);
		frm(8'h0b, 8'h14);
		chk({lamp_on_q, arc_level_q}, {1'b1, 8'h90});
	endtask
	task automatic t_silent();
		logic [15:0] f[4] = '{16'h0bf0, 16'h0bb7, 16'h0c90, 16'h0a90};
		foreach (f[i]) begin
			m.send(f[i], 1'b0);
			m.reply(got, rb);
			chk(got, 1'b0);
		end
		chk({arc_level_q, groups_q, short_addr_q}, {8'h90, 16'h0008, 6'h05});
	endtask
	task automatic t_query();
		logic [7:0] c[5] = '{8'h90, 8'ha0, 8'h92, 8'h92, 8'h90};
		logic [4:0] fl = 5'b11000;
		logic [4:0] rp = 5'b11011;
		logic [7:0] v[5] = '{8'h02, 8'h90, 8'h00, 8'hff, 8'h03};
		foreach (c[i]) begin
			lamp_fail <= fl[i];
			m.send({8'h0b, c[i]}, 1'b0);
			m.reply(got, rb);
			chk({got, got ? rb : 8'h00}, {rp[4 - i], v[i]});
		end
		lamp_fail <= 1'b0;
	endtask
	task automatic t_config();
		int s0;
		s0 = saves;
		frm(8'ha3, 8'h13);
		frm(8'h0b, 8'h80);
		chk({addr_valid_q, short_addr_q}, {1'b1, 6'h09});
		frm(8'h13, 8'h65);
		frm(8'h13, 8'h73);
		chk(groups_q, 16'h0020);
		chk(saves - s0, 3);
	endtask
	task automatic t_bad_stop();
		m.send(16'h1300, 1'b1);
		repeat (8) @(posedge mclk);
		chk({ferr, lamp_on_q, arc_level_q}, {1'b1, 1'b1, 8'h90});
	endtask
	initial begin
		repeat (60000) @(posedge mclk);
		error_cnt++;
		summarize();
	end
	initial begin
		repeat (12) @(posedge mclk);
		nrst <= 1'b1;
		repeat (4) @(posedge mclk);
		t_restore();
		t_level();
		t_group();
		t_scene();
		t_silent();
		t_query();
		t_config();
		t_bad_stop();
		summarize();
	end
endmodule
